// >>> src/fci_host.sv
// flash command host: apb registers, command sequences and status polling
// Contract
// - instructions take one to six bus cycles
// - unlock pair first, repeated before erase confirm
// - fixed command byte codes
// - ignore data lines 0,1,2,4 in status
// - poll at programmed byte or erased block
// - two equal toggles mean finished
// - unlock: AA at 5555, 55 at 2AAA
// - wait 5 us after reset before reads
// - chip erase six writes, confirm 10
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fci_host
    import fci_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [18:0] flash_addr_o,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe_o,
    input wire logic [7:0] data_lines_i,
    output logic chip_select_n_o,
    output logic write_strobe_n_o,
    output logic output_strobe_n_o
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_WR = 5'b00010,
        S_POLL = 5'b00100,
        S_FINAL = 5'b01000,
        S_WAIT = 5'b10000
    } fci_st_t;

    function automatic logic [2:0] seq_len(input fci_op_t op);
        unique case (op)
            OP_READ: seq_len = 3'd0;
            OP_PROGRAM: seq_len = 3'd4;
            OP_BLOCK_ERASE, OP_CHIP_ERASE: seq_len = 3'd6;
            OP_QUERY: seq_len = 3'd3;
            OP_PAUSE, OP_RESUME, OP_RESET: seq_len = 3'd1;
        endcase
    endfunction

    function automatic fci_cyc_t seq_step(input fci_op_t op, input logic [2:0] idx,
                                          input logic [18:0] a, input logic [7:0] d);
        fci_cyc_t c;
        c.wr = 1'b1;
        c.addr = UNLOCK1_ADDR;
        c.data = UNLOCK1_DATA;
        if (op == OP_RESET) begin
            c.data = CMD_RESET;
        end else if (op == OP_PAUSE) begin
            c.addr = a;
            c.data = CMD_PAUSE;
        end else if (op == OP_RESUME) begin
            c.addr = a;
            c.data = CMD_BLOCK_CONFIRM;
        end else if (idx == 3'd1 || idx == 3'd4) begin
            c.addr = UNLOCK2_ADDR;
            c.data = UNLOCK2_DATA;
        end else if (idx == 3'd2) begin
            c.data = (op == OP_PROGRAM) ? CMD_PROGRAM :
                     (op == OP_QUERY) ? CMD_QUERY : CMD_ERASE_SETUP;
        end else if (idx == 3'd3 && op == OP_PROGRAM) begin
            c.addr = a;
            c.data = d;
        end else if (idx == 3'd5) begin
            c.addr = (op == OP_CHIP_ERASE) ? UNLOCK1_ADDR : a;
            c.data = (op == OP_CHIP_ERASE) ? CMD_CHIP_CONFIRM : CMD_BLOCK_CONFIRM;
        end
        return c;
    endfunction

    fci_st_t st_q, st_d;
    fci_op_t op_q, op_d, ctrl_op_q, ctrl_op_d;
    logic [2:0] idx_q, idx_d;
    logic [18:0] addr_q, addr_d, tgt_q, tgt_d;
    logic [7:0] wdata_q, wdata_d, stat_q, stat_d, rd_q, rd_d;
    logic req_q, req_d, prev_q, prev_d, have_q, have_d;
    logic done_q, done_d, err_q, err_d;
    logic [7:0] wait_q, wait_d;
    logic [31:0] prdata_q, prdata_d;
    fci_cyc_t cyc_q, cyc_d;
    logic ack;
    logic [7:0] bus_rd;
    logic wr_acc, go, mapped;

    assign mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) ||
                    (paddr == REG_DATA) || (paddr == REG_STAT);
    assign wr_acc = psel && penable && pwrite && mapped;
    assign go = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_START_BIT] && (st_q == S_IDLE);

    always_comb begin
        ctrl_op_d = ctrl_op_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        prdata_d = prdata_q;
        if (wr_acc && paddr == REG_CTRL) begin
            ctrl_op_d = fci_op_t'(pwdata[2:0]);
        end
        if (wr_acc && paddr == REG_ADDR) begin
            addr_d = pwdata[18:0];
        end
        if (wr_acc && paddr == REG_DATA) begin
            wdata_d = pwdata[7:0];
        end
        // captured in the setup phase so the slave answers without wait states
        if (psel && !penable) begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                REG_CTRL: prdata_d[2:0] = ctrl_op_q;
                REG_ADDR: prdata_d[18:0] = addr_q;
                REG_DATA: prdata_d[7:0] = wdata_q;
                REG_STAT: begin
                    prdata_d[STAT_BUSY_BIT] = (st_q != S_IDLE);
                    prdata_d[STAT_DONE_BIT] = done_q;
                    prdata_d[STAT_ERR_BIT] = err_q;
                    prdata_d[STAT_BYTE_LSB +: 8] = stat_q;
                    prdata_d[STAT_RDATA_LSB +: 8] = rd_q;
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        st_d = st_q;
        op_d = op_q;
        idx_d = idx_q;
        tgt_d = tgt_q;
        stat_d = stat_q;
        rd_d = rd_q;
        // one-cycle request: a standing one would be taken again after ack
        req_d = 1'b0;
        prev_d = prev_q;
        have_d = have_q;
        done_d = done_q;
        err_d = err_q;
        wait_d = wait_q;
        cyc_d = cyc_q;
        unique case (st_q)
            S_IDLE: begin
                if (go) begin
                    op_d = fci_op_t'(pwdata[2:0]);
                    tgt_d = addr_q;
                    idx_d = 3'd0;
                    done_d = 1'b0;
                    err_d = 1'b0;
                    req_d = 1'b1;
                    if (seq_len(fci_op_t'(pwdata[2:0])) == 3'd0) begin
                        cyc_d = '{wr: 1'b0, addr: addr_q, data: DATA_RST};
                        st_d = S_FINAL;
                    end else begin
                        cyc_d = seq_step(fci_op_t'(pwdata[2:0]), 3'd0, addr_q, wdata_q);
                        st_d = S_WR;
                    end
                end
            end
            S_WR: begin
                if (ack) begin
                    if (idx_q + 3'd1 < seq_len(op_q)) begin
                        idx_d = idx_q + 3'd1;
                        cyc_d = seq_step(op_q, idx_q + 3'd1, tgt_q, wdata_q);
                        req_d = 1'b1;
                    end else if (op_q == OP_RESET) begin
                        wait_d = 8'h00;
                        st_d = S_WAIT;
                    end else begin
                        cyc_d = '{wr: 1'b0, addr: tgt_q, data: DATA_RST};
                        req_d = 1'b1;
                        have_d = 1'b0;
                        st_d = (op_q == OP_READ || op_q == OP_QUERY) ? S_FINAL : S_POLL;
                    end
                end
            end
            S_POLL: begin
                if (ack) begin
                    stat_d = bus_rd & STATUS_MASK;
                    req_d = 1'b1;
                    if (have_q && bus_rd[DQ_TOGGLE] == prev_q) begin
                        st_d = S_FINAL;
                    end else if (have_q && bus_rd[DQ_ERROR] && stat_q[DQ_ERROR]) begin
                        // error flag on two toggling reads in a row; a single one may
                        // be array data read just as the operation finished
                        err_d = 1'b1;
                        op_d = OP_RESET;
                        idx_d = 3'd0;
                        cyc_d = seq_step(OP_RESET, 3'd0, tgt_q, wdata_q);
                        st_d = S_WR;
                    end else begin
                        prev_d = bus_rd[DQ_TOGGLE];
                        have_d = 1'b1;
                    end
                end
            end
            S_FINAL: begin
                if (ack) begin
                    rd_d = bus_rd;
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            S_WAIT: begin
                if (wait_q == 8'(RST_WAIT_CYC - 1)) begin
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end else begin
                    wait_d = wait_q + 8'h01;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_q <= S_IDLE;
            op_q <= OP_READ;
            ctrl_op_q <= OP_READ;
            idx_q <= 3'd0;
            addr_q <= ADDR_RST;
            tgt_q <= ADDR_RST;
            wdata_q <= DATA_RST;
            stat_q <= DATA_RST;
            rd_q <= DATA_RST;
            req_q <= 1'b0;
            prev_q <= 1'b0;
            have_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            wait_q <= 8'h00;
            prdata_q <= 32'h0000_0000;
            cyc_q <= '0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            ctrl_op_q <= ctrl_op_d;
            idx_q <= idx_d;
            addr_q <= addr_d;
            tgt_q <= tgt_d;
            wdata_q <= wdata_d;
            stat_q <= stat_d;
            rd_q <= rd_d;
            req_q <= req_d;
            prev_q <= prev_d;
            have_q <= have_d;
            done_q <= done_d;
            err_q <= err_d;
            wait_q <= wait_d;
            prdata_q <= prdata_d;
            cyc_q <= cyc_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // strobes follow the device's capture edges: address before fall, data past rise
    fci_bus_cycle u_cycle (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .req_i(req_q),
        .cyc_i(cyc_q),
        .ack_o(ack),
        .rdata_o(bus_rd),
        .flash_addr_o(flash_addr_o),
        .data_lines_o(data_lines_o),
        .data_lines_oe_o(data_lines_oe_o),
        .data_lines_i(data_lines_i),
        .chip_select_n_o(chip_select_n_o),
        .write_strobe_n_o(write_strobe_n_o),
        .output_strobe_n_o(output_strobe_n_o)
    );

    unlock_first_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_WR && idx_q == 3'd0 && seq_len(op_q) > 3'd1)
        |-> (cyc_q.addr == UNLOCK1_ADDR && cyc_q.data == UNLOCK1_DATA))
        else $error("first unlock write wrong");
    unlock_second_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_WR && (idx_q == 3'd1 || idx_q == 3'd4) && seq_len(op_q) > 3'd1)
        |-> (cyc_q.addr == UNLOCK2_ADDR && cyc_q.data == UNLOCK2_DATA))
        else $error("second unlock write wrong");
    prog_data_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_WR && op_q == OP_PROGRAM && idx_q == 3'd3)
        |-> (cyc_q.wr && cyc_q.addr == tgt_q && cyc_q.data == wdata_q))
        else $error("program data write wrong");
    chip_confirm_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_WR && op_q == OP_CHIP_ERASE && idx_q == 3'd5)
        |-> (cyc_q.addr == UNLOCK1_ADDR && cyc_q.data == CMD_CHIP_CONFIRM))
        else $error("chip erase confirm wrong");
    seq_bound_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_WR && ack) |=> (st_q != S_WR || (idx_q < 3'd6 && idx_q != 3'd0)))
        else $error("instruction longer than six writes");
    poll_addr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_POLL && req_q) |-> (!cyc_q.wr && cyc_q.addr == tgt_q))
        else $error("poll read at wrong address");
    rst_wait_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_WR && op_q == OP_RESET && ack) |=> (st_q == S_WAIT && !req_q) [*8])
        else $error("read issued too soon after reset");
    wait_len_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_WAIT && wait_q < 8'(RST_WAIT_CYC - 1)) |=> st_q == S_WAIT)
        else $error("reset wait cut short");
    stat_mask_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (stat_q & ~STATUS_MASK) == 8'h00)
        else $error("reserved status lines kept");
    done_toggle_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_POLL && !(ack && have_q && bus_rd[DQ_TOGGLE] == prev_q))
        |=> st_q != S_FINAL)
        else $error("poll end without equal toggles");
    final_after_equal_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q == S_POLL && ack && have_q && bus_rd[DQ_TOGGLE] == prev_q) |=> st_q == S_FINAL)
        else $error("equal toggles did not end polling");
endmodule

// >>> src/fci_pkg.sv
// shared constants, types and register map of the flash command host
package fci_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned RST_WAIT_NS = 5000;
    localparam int unsigned RST_WAIT_CYC = (RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_NS = 25;
    localparam int unsigned STROBE_NS = 50;
    localparam int unsigned HOLD_NS = 25;
    localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned ADDR_W = 19;
    localparam logic [18:0] UNLOCK1_ADDR = 19'h05555;
    localparam logic [18:0] UNLOCK2_ADDR = 19'h02AAA;
    localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;

    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_CHIP_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_QUERY = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_PAUSE = 8'hB0;
    localparam logic [7:0] CMD_RESET = 8'hF0;

    localparam int unsigned DQ_POLL = 7;
    localparam int unsigned DQ_TOGGLE = 6;
    localparam int unsigned DQ_ERROR = 5;
    localparam int unsigned DQ_WINDOW = 3;
    localparam logic [7:0] STATUS_MASK = 8'hE8;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_ADDR = 12'h004;
    localparam logic [11:0] REG_DATA = 12'h008;
    localparam logic [11:0] REG_STAT = 12'h00C;
    localparam int unsigned CTRL_START_BIT = 8;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_DONE_BIT = 1;
    localparam int unsigned STAT_ERR_BIT = 2;
    localparam int unsigned STAT_BYTE_LSB = 8;
    localparam int unsigned STAT_RDATA_LSB = 16;
    localparam logic [18:0] ADDR_RST = 19'h00000;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_BLOCK_ERASE = 3'h2,
        OP_CHIP_ERASE = 3'h3,
        OP_PAUSE = 3'h4,
        OP_RESUME = 3'h5,
        OP_RESET = 3'h6,
        OP_QUERY = 3'h7
    } fci_op_t;

    typedef struct packed {
        logic wr;
        logic [18:0] addr;
        logic [7:0] data;
    } fci_cyc_t;
endpackage

// >>> src/fci_bus_cycle.sv
// one write or read cycle on the flash pins
`timescale 1ns/1ps
module fci_bus_cycle
    import fci_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic req_i,
    input wire fci_cyc_t cyc_i,
    output logic ack_o,
    output logic [7:0] rdata_o,
    output logic [18:0] flash_addr_o,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe_o,
    input wire logic [7:0] data_lines_i,
    output logic chip_select_n_o,
    output logic write_strobe_n_o,
    output logic output_strobe_n_o
);
    typedef enum logic [3:0] {
        E_IDLE = 4'b0001,
        E_SETUP = 4'b0010,
        E_STROBE = 4'b0100,
        E_HOLD = 4'b1000
    } fci_eng_t;

    fci_eng_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    fci_cyc_t cyc_q, cyc_d;
    logic ack_q, ack_d;
    logic [7:0] rd_q, rd_d;
    logic cs_q, cs_d, we_q, we_d, oe_q, oe_d, dqoe_q, dqoe_d;

    // address and select settle before the strobe falls, so the device's
    // address capture sees stable lines; the strobe rises before select
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        cyc_d = cyc_q;
        ack_d = 1'b0;
        rd_d = rd_q;
        cs_d = cs_q;
        we_d = we_q;
        oe_d = oe_q;
        dqoe_d = dqoe_q;
        unique case (st_q)
            E_IDLE: begin
                if (req_i) begin
                    cyc_d = cyc_i;
                    cs_d = 1'b1;
                    dqoe_d = cyc_i.wr;
                    cnt_d = 4'(SETUP_CYC - 1);
                    st_d = E_SETUP;
                end
            end
            E_SETUP: begin
                if (cnt_q == 4'h0) begin
                    we_d = cyc_q.wr;
                    oe_d = !cyc_q.wr;
                    cnt_d = 4'(STROBE_CYC - 1);
                    st_d = E_STROBE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            E_STROBE: begin
                if (cnt_q == 4'h0) begin
                    if (!cyc_q.wr) begin
                        rd_d = data_lines_i;
                    end
                    we_d = 1'b0;
                    oe_d = 1'b0;
                    cnt_d = 4'(HOLD_CYC - 1);
                    st_d = E_HOLD;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            E_HOLD: begin
                if (cnt_q == 4'h0) begin
                    cs_d = 1'b0;
                    dqoe_d = 1'b0;
                    ack_d = 1'b1;
                    st_d = E_IDLE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: st_d = E_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_q <= E_IDLE;
            cnt_q <= 4'h0;
            cyc_q <= '0;
            ack_q <= 1'b0;
            rd_q <= 8'h00;
            cs_q <= 1'b0;
            we_q <= 1'b0;
            oe_q <= 1'b0;
            dqoe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cyc_q <= cyc_d;
            ack_q <= ack_d;
            rd_q <= rd_d;
            cs_q <= cs_d;
            we_q <= we_d;
            oe_q <= oe_d;
            dqoe_q <= dqoe_d;
        end
    end

    assign ack_o = ack_q;
    assign rdata_o = rd_q;
    assign flash_addr_o = cyc_q.addr;
    assign data_lines_o = cyc_q.data;
    assign data_lines_oe_o = dqoe_q;
    assign chip_select_n_o = !cs_q;
    assign write_strobe_n_o = !we_q;
    assign output_strobe_n_o = !oe_q;
endmodule

// >>> verif/fci_flash_model.sv
// behavioural byte-wide flash device on the far side of the host
`timescale 1ns/1ps
module fci_flash_model
    import fci_pkg::*;
#(
    parameter int unsigned PROT_BLK = 7,
    parameter int unsigned BUSY_READS = 4,
    parameter logic [7:0] QUERY_CODE = 8'h3C // arbitrary value
)(
    input wire logic [18:0] addr_i,
    input wire logic [7:0] dq_i,
    input wire logic cs_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic fail_i,
    output logic drive_o = 1'b0,
    output logic [7:0] dq_o
);
    logic [7:0] mem [int];
    logic [18:0] la;
    logic [7:0] r;
    logic tog = 1'b0, err = 1'b0, ers = 1'b0, qry = 1'b0, hold = 1'b0, pb = 1'b0;
    int step = 0, busy = 0;

    function automatic logic [7:0] rd(input logic [18:0] x);
        return mem.exists(x) ? mem[x] : 8'hFF;
    endfunction

    // protected blocks still report busy for a while
    task automatic erase(input logic [18:0] a, input logic chip);
        ers = 1'b1;
        busy = BUSY_READS;
        foreach (mem[k])
            if (k[18:16] != PROT_BLK[2:0] && (chip || k[18:16] == a[18:16])) mem[k] = 8'hFF;
    endtask

    task automatic cmd(input logic [18:0] a, input logic [7:0] d);
        if (d == CMD_RESET) begin
            step = 0;
            busy = 0;
            err = 1'b0;
            qry = 1'b0;
            hold = 1'b0;
        end else if (busy > 0) begin
            if (d == CMD_PAUSE) hold = 1'b1;
            if (d == CMD_BLOCK_CONFIRM) hold = 1'b0;
        end else begin
            case (step)
                0, 3: step = (a == UNLOCK1_ADDR && d == UNLOCK1_DATA) ? step + 1 : 0;
                1, 4: step = (a == UNLOCK2_ADDR && d == UNLOCK2_DATA) ? step + 1 : 0;
                2: begin
                    qry = (a == UNLOCK1_ADDR && d == CMD_QUERY);
                    step = a != UNLOCK1_ADDR ? 0 : d == CMD_PROGRAM ? 6 :
                        d == CMD_ERASE_SETUP ? 3 : 0;
                end
                5: begin
                    step = 0;
                    if (d == CMD_BLOCK_CONFIRM) erase(a, 1'b0);
                    if (d == CMD_CHIP_CONFIRM && a == UNLOCK1_ADDR) erase(a, 1'b1);
                end
                default: begin
                    step = 0;
                    ers = 1'b0;
                    pb = d[7];
                    if (a[18:16] != PROT_BLK[2:0]) busy = BUSY_READS;
                    if (a[18:16] != PROT_BLK[2:0]) mem[a] = rd(a) & d;
                end
            endcase
        end
    endtask

    always @(negedge we_n_i) if (!cs_n_i) la = addr_i;
    always @(posedge we_n_i) if (!cs_n_i) cmd(la, dq_i);
    always @(posedge oe_n_i or posedge cs_n_i) drive_o = 1'b0;
    always @(negedge oe_n_i or negedge cs_n_i) if (!cs_n_i && !oe_n_i) begin
        r = 8'($urandom);
        drive_o = 1'b1;
        if (busy > 0) begin
            if (!hold) tog = ~tog;
            dq_o = {ers ? 1'b0 : ~pb, tog, err, r[4], ~ers | busy < BUSY_READS, r[2:0]};
            if (!hold && busy == 1 && fail_i) err = 1'b1;
            else if (!hold) busy--;
        end else dq_o = qry ? QUERY_CODE : rd(addr_i);
    end
endmodule

// >>> verif/fci_host_tb.sv
// self-checking bench for the flash command host
`timescale 1ns/1ps
module fci_host_tb
    import fci_pkg::*;
;
    localparam logic [2:0] PROT = 3'h7;
    localparam logic [7:0] QCODE = 8'h3C; // arbitrary value
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fail = 1'b0, serr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, st;
    logic pready, pslverr, oe, cs_n, we_n, re_n, drv;
    logic [18:0] fa, a;
    logic [7:0] dlo, mdq, dq, d;
    logic [7:0] ref_mem [int];
    int mismatches = 0, n_tests = 0, cyc = 0;

    // a released bus wanders instead of keeping its last value
    assign dq = oe ? dlo : drv ? mdq : cyc[7:0] ^ 8'hA5;
    always #12.5 ref_clk_i = ~ref_clk_i;

    fci_host uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr_o(fa), .data_lines_o(dlo), .data_lines_oe_o(oe),
        .data_lines_i(dq), .chip_select_n_o(cs_n), .write_strobe_n_o(we_n),
        .output_strobe_n_o(re_n));
    fci_flash_model #(.PROT_BLK(PROT), .QUERY_CODE(QCODE)) dev (.addr_i(fa), .dq_i(dq),
        .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(re_n), .fail_i(fail), .drive_o(drv), .dq_o(mdq));

    task automatic test_done();
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
        chk_w({24'h0, got}, {24'h0, exp});
    endtask

    function automatic logic [7:0] ref_rd(input logic [18:0] x);
        return ref_mem.exists(x) ? ref_mem[x] : 8'hFF;
    endfunction

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        st = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic op(input fci_op_t o, input logic [18:0] oa, input logic [7:0] od);
        apb(1'b1, REG_ADDR, {13'h0, oa});
        apb(1'b1, REG_DATA, {24'h0, od});
        apb(1'b1, REG_CTRL, {23'h0, 1'b1, 5'h0, o});
        apb(1'b0, REG_STAT, 32'h0);
        for (int i = 0; i < 500 && st[STAT_DONE_BIT] !== 1'b1; i++) apb(1'b0, REG_STAT, 32'h0);
        chk_w({29'h0, st[2:0]}, {29'h0, fail, 2'b10});
    endtask

    task automatic prog(input logic [18:0] pa, input logic [7:0] pd);
        if (pa[18:16] != PROT) ref_mem[pa] = ref_rd(pa) & pd;
        op(OP_PROGRAM, pa, pd);
        if (!fail) chk_b(st[23:16], ref_rd(pa));
    endtask

    task automatic er(input fci_op_t o, input logic [18:0] ea);
        op(o, ea, 8'h00);
        foreach (ref_mem[k])
            if (k[18:16] != PROT && (o == OP_CHIP_ERASE || k[18:16] == ea[18:16])) ref_mem[k] = 8'hFF;
        op(OP_READ, ea, 8'h00);
        chk_b(st[23:16], 8'hFF);
    endtask

    initial begin
        void'($urandom(63));
        repeat (20) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        apb(1'b0, REG_ADDR, 32'h0);
        chk_w(st, 32'h0);
        apb(1'b0, REG_STAT, 32'h0);
        chk_w(st, 32'h0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk_w({31'h0, serr}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk_w(st, 32'h0);
        repeat (6) begin
            a = {3'($urandom_range(6)), 16'($urandom)};
            d = 8'($urandom);
            prog(a, d);
            prog(a, ~d ^ 8'h11);
            op(OP_READ, a, 8'h00);
            chk_b(st[23:16], ref_rd(a));
        end
        prog({PROT, 16'h0ABC}, 8'h00);
        er(OP_BLOCK_ERASE, a);
        fail <= 1'b1;
        prog(a, 8'h5A);
        fail <= 1'b0;
        op(OP_RESET, a, 8'h00);
        prog(a ^ 19'h00001, 8'hC3);
        op(OP_PAUSE, a, 8'h00);
        op(OP_RESUME, a, 8'h00);
        op(OP_QUERY, a, 8'h00);
        chk_b(st[23:16], QCODE);
        er(OP_CHIP_ERASE, a ^ 19'h10000);
        test_done();
    end
endmodule
